//--- core/upw_pkg.sv
package upw_pkg;

  // Power-saving settings
  localparam logic [1:0] PSV_OFF    = 2'h0;
  localparam logic [1:0] PSV_CYCLIC = 2'h1;
  localparam logic [1:0] PSV_RTS    = 2'h2;
  localparam logic [1:0] PSV_DTR    = 2'h3;
  localparam logic [1:0] PSV_RESET  = PSV_OFF;

  // Timing
  localparam int CLK_HZ          = 250_000_000;
  localparam int WAKE_TIME_US    = 5000;
  localparam int WAKE_CYCLES     = CLK_HZ / 1_000_000 * WAKE_TIME_US;
  localparam int FRAME_TIME_NS   = 4615000;
  localparam int FRAME_CYCLES    = FRAME_TIME_NS / 4;
  localparam logic [15:0] IDLE_FRAMES_MIN   = 16'h0028;
  localparam logic [15:0] IDLE_FRAMES_MAX   = 16'hFDE8;
  localparam logic [15:0] IDLE_FRAMES_RESET = 16'h07D0;

  // Fields of the status word
  localparam int ST_UART_EN  = 0;
  localparam int ST_ACTIVE   = 1;
  localparam int ST_WAKE_ARM = 2;
  localparam int ST_WAKING   = 3;

endpackage

//--- core/upw_stream_if.sv
`timescale 1ns/1ps
interface upw_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

//--- core/upw_fifo.sv
`timescale 1ns/1ps
module upw_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic ref_clk_i,    // Clock
  input  wire logic srst_i,       // Sync reset
  upw_stream_if.sink in_s,        // Fill side
  upw_stream_if.src  out_s        // Drain side
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } upw_fifo_st_t;

  upw_fifo_st_t s_r;
  upw_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  assign in_s.ready  = (s_r.cnt != (AW+1)'(D));
  assign out_s.valid = (s_r.cnt != '0);
  assign out_s.data  = s_r.mem[s_r.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_s.data;
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

//--- core/upw_ctrl.sv
`timescale 1ns/1ps
module upw_ctrl #(
  parameter int          WAKE_CNT  = upw_pkg::WAKE_CYCLES,
  parameter int          FRAME_CNT = upw_pkg::FRAME_CYCLES,
  parameter int          DW        = 8,
  parameter int          DEPTH     = 16
) (
  input  wire logic          ref_clk_i,        // Clock, 250 MHz
  input  wire logic          srst_i,           // Sync reset, high
  input  wire logic [1:0]    power_save_setting_i, // Requested setting
  input  wire logic          flow_control_on_setting_i, // HW flow on
  input  wire logic [15:0]   idle_frames_i,    // Idle timeout, frames
  input  wire logic [1:0]    terminal_ready_action_setting_i, // DTR action
  input  wire logic          rts_on_i,         // RTS line is ON
  input  wire logic          dtr_on_i,         // DTR line is ON
  input  wire logic          txd_i,            // DTE transmit-data line
  input  wire logic          uart_init_done_i, // UART initialised
  input  wire logic          rx_valid_i,       // Received char strobe
  input  wire logic [DW-1:0] rx_data_i,        // Received char
  input  wire logic          unsolicited_result_i, // Own data pending
  input  wire logic          usb_active_i,     // USB attached, awake
  input  wire logic          work_pending_i,   // Network or iface work
  input  wire logic          host_rd_ready_i,  // Consumer takes a char
  output logic               host_rd_valid_o,  // Char available
  output logic [DW-1:0]      host_rd_data_o,   // Char data
  output logic               rx_fifo_ready_o,  // FIFO not full
  output logic               cts_n_o,          // CTS, low = ON
  output logic               uart_en_o,        // UART enabled
  output logic               module_active_o,  // Module active
  output logic               wake_armed_o,     // Data wake armed
  output logic [1:0]         active_setting_o, // Accepted setting
  output logic               setting_refused_o,// Request refused
  output logic               dtr_drop_o,       // DTR ON-to-OFF pulse
  output logic [1:0]         dtr_action_o      // Action to apply
);

  //****************************************************************
  // State
  //****************************************************************
  typedef enum logic [1:0] {
    UPW_IDLE,
    UPW_WAKING,
    UPW_ON
  } upw_state_t;

  typedef struct packed {
    upw_state_t  st;
    logic [1:0]  psv;
    logic        refused;
    logic        rts_q;
    logic        dtr_q;
    logic        txd_q;
    logic        data_hold;
    logic        drop_next;
    logic [31:0] wake_cnt;
    logic [31:0] frame_cnt;
    logic [15:0] frames;
    logic        cts_n;
    logic        uart_en;
    logic        active;
    logic        armed;
    logic        dtr_drop;
    logic [1:0]  dtr_act;
  } upw_ctrl_st_t;

  upw_ctrl_st_t s_r;
  upw_ctrl_st_t s_nxt;

  //****************************************************************
  // Receive FIFO
  //****************************************************************
  upw_stream_if #(.W(DW)) fill_s ();
  upw_stream_if #(.W(DW)) drain_s ();

  logic rx_accept;

  upw_fifo #(
    .W (DW),
    .D (DEPTH)
  ) u_fifo (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .in_s      (fill_s),
    .out_s     (drain_s)
  );

  // Chars only land while awake and not the wake character
  assign rx_accept     = (s_r.st == UPW_ON) && !s_r.drop_next;
  assign fill_s.valid  = rx_valid_i && rx_accept;
  assign fill_s.data   = rx_data_i;
  assign drain_s.ready = host_rd_ready_i;
  assign host_rd_valid_o = drain_s.valid;
  assign host_rd_data_o  = drain_s.data;
  assign rx_fifo_ready_o = fill_s.ready;

  //****************************************************************
  // Next state
  //****************************************************************
  logic        line_en;
  logic        line_rise;
  logic        txd_rise;
  logic        timer_out;
  logic        want_uart;
  logic [15:0] frames_lim;

  always_comb
  begin
    s_nxt = s_r;
    want_uart = 1'b1;
    s_nxt.rts_q = rts_on_i;
    s_nxt.dtr_q = dtr_on_i;
    s_nxt.txd_q = txd_i;
    s_nxt.dtr_drop = s_r.dtr_q && !dtr_on_i;
    s_nxt.dtr_act  = terminal_ready_action_setting_i;

    // Setting acceptance
    s_nxt.refused = 1'b0;
    if (power_save_setting_i != s_r.psv)
    begin
      if (power_save_setting_i == upw_pkg::PSV_RTS &&
          flow_control_on_setting_i)
        s_nxt.refused = 1'b1;
      else
        s_nxt.psv = power_save_setting_i;
    end

    frames_lim = idle_frames_i;
    if (frames_lim < upw_pkg::IDLE_FRAMES_MIN)
      frames_lim = upw_pkg::IDLE_FRAMES_MIN;
    if (frames_lim > upw_pkg::IDLE_FRAMES_MAX)
      frames_lim = upw_pkg::IDLE_FRAMES_MAX;

    line_en   = 1'b0;
    line_rise = 1'b0;
    unique case (s_r.psv)
      upw_pkg::PSV_RTS:
      begin
        line_en   = rts_on_i;
        line_rise = rts_on_i && !s_r.rts_q;
      end
      upw_pkg::PSV_DTR:
      begin
        line_en   = dtr_on_i;
        line_rise = dtr_on_i && !s_r.dtr_q;
      end
      upw_pkg::PSV_OFF,
      upw_pkg::PSV_CYCLIC:
      begin
        line_en   = 1'b0;
        line_rise = 1'b0;
      end
    endcase

    // Data wake armed only with flow control off, in cyclic mode or with the selected line OFF
    s_nxt.armed = !flow_control_on_setting_i &&
                  ((s_r.psv == upw_pkg::PSV_CYCLIC) ||
                   (s_r.psv == upw_pkg::PSV_RTS && !rts_on_i) ||
                   (s_r.psv == upw_pkg::PSV_DTR && !dtr_on_i));
    txd_rise = txd_i && !s_r.txd_q;

    // Frame-based idle timer, restarted by each char received in UPW_ON
    // Hold flag only set by a data wake, so line OFF still disables
    timer_out = (s_r.frames == '0);
    if (rx_valid_i && s_r.st == UPW_ON)
    begin
      s_nxt.frames    = frames_lim;
      s_nxt.frame_cnt = '0;
    end
    else if (!timer_out)
    begin
      if (s_r.frame_cnt == 32'(FRAME_CNT - 1))
      begin
        s_nxt.frame_cnt = '0;
        s_nxt.frames    = s_r.frames - 16'h0001;
      end
      else
        s_nxt.frame_cnt = s_r.frame_cnt + 32'h1;
    end
    else
      s_nxt.data_hold = 1'b0;

    if (rx_valid_i && s_r.drop_next)
      s_nxt.drop_next = 1'b0;

    unique case (s_r.st)
      UPW_IDLE:
      begin
        if ((s_r.armed && txd_rise) || line_rise)
        begin
          s_nxt.st        = UPW_WAKING;
          s_nxt.wake_cnt  = '0;
          s_nxt.drop_next = s_r.armed && txd_rise;
          s_nxt.frames    = frames_lim;
          s_nxt.frame_cnt = '0;
          s_nxt.data_hold = s_r.armed && txd_rise;
        end
        else if (line_en || s_r.psv == upw_pkg::PSV_OFF)
          s_nxt.st = UPW_ON;
      end
      UPW_WAKING:
      begin
        s_nxt.drop_next = 1'b0;
        if (s_r.wake_cnt == 32'(WAKE_CNT - 1))
          s_nxt.st = UPW_ON;
        else
          s_nxt.wake_cnt = s_r.wake_cnt + 32'h1;
      end
      UPW_ON:
      begin
        unique case (s_r.psv)
          upw_pkg::PSV_OFF:
            want_uart = 1'b1;
          upw_pkg::PSV_CYCLIC:
            want_uart = !timer_out;
          upw_pkg::PSV_RTS,
          upw_pkg::PSV_DTR:
            want_uart = line_en || s_r.data_hold;
        endcase
        if (!want_uart)
          s_nxt.st = UPW_IDLE;
      end
      default:
        s_nxt.st = UPW_IDLE;
    endcase
    if (s_r.psv == upw_pkg::PSV_OFF)
      s_nxt.st = UPW_ON;

    // Outputs
    s_nxt.uart_en = uart_init_done_i &&
                    ((s_nxt.st == UPW_ON) ||
                     unsolicited_result_i);
    // CTS ON only when UART initialised, in UPW_ON and FIFO has room
    s_nxt.cts_n = !(uart_init_done_i && s_nxt.st == UPW_ON &&
                    fill_s.ready);
    s_nxt.active = (s_nxt.st != UPW_IDLE) || work_pending_i ||
                   usb_active_i || unsolicited_result_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_r           <= '0;
      s_r.st        <= UPW_ON;
      s_r.psv       <= upw_pkg::PSV_RESET;
      s_r.frames    <= upw_pkg::IDLE_FRAMES_RESET;
      s_r.cts_n     <= 1'b1;
      s_r.active    <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  //****************************************************************
  // Outputs
  //****************************************************************
  assign cts_n_o           = s_r.cts_n;
  assign uart_en_o         = s_r.uart_en;
  assign module_active_o   = s_r.active;
  assign wake_armed_o      = s_r.armed;
  assign active_setting_o  = s_r.psv;
  assign setting_refused_o = s_r.refused;
  assign dtr_drop_o        = s_r.dtr_drop;
  assign dtr_action_o      = s_r.dtr_act;

endmodule

//--- bench/upw_ctrl_properties.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module upw_ctrl_properties #(
  parameter int WAKE_CNT = 10
) (
  input wire logic       ref_clk_i,                 // Clk
  input wire logic       srst_i,                    // Rst
  input wire logic [1:0] power_save_setting_i,      // Req
  input wire logic       flow_control_on_setting_i, // Flow
  input wire logic       dtr_on_i,                  // DTR
  input wire logic       txd_i,                     // TXD
  input wire logic       usb_active_i,              // USB
  input wire logic       uart_init_done_i,          // Init
  input wire logic       rx_fifo_ready_o,           // Room
  input wire logic       cts_n_o,                   // CTS
  input wire logic       uart_en_o,                 // En
  input wire logic       module_active_o,           // Act
  input wire logic       wake_armed_o,              // Arm
  input wire logic [1:0] active_setting_o,          // Set
  input wire logic       setting_refused_o,         // Ref
  input wire logic       dtr_drop_o                 // Drop
);
  localparam int WK_HI = WAKE_CNT + 4;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  property p_cts_en;
    !cts_n_o |-> uart_en_o;
  endproperty
  a_cts_en: assert property (p_cts_en) else $error("cts on, uart off");
  property p_full;
    !rx_fifo_ready_o [*2] |-> cts_n_o;
  endproperty
  a_full: assert property (p_full) else $error("cts on while full");
  property p_set0;
    (active_setting_o == 2'h0 && uart_init_done_i && rx_fifo_ready_o) [*3]
      |-> !cts_n_o;
  endproperty
  a_set0: assert property (p_set0) else $error("cts off in mode 0");
  property p_take;
    power_save_setting_i != active_setting_o &&
      !(power_save_setting_i == 2'h2 && flow_control_on_setting_i)
      |=> active_setting_o == $past(power_save_setting_i);
  endproperty
  a_take: assert property (p_take) else $error("setting not taken");
  property p_refuse;
    power_save_setting_i == 2'h2 && flow_control_on_setting_i &&
      active_setting_o != 2'h2 |=> setting_refused_o && active_setting_o != 2'h2;
  endproperty
  a_refuse: assert property (p_refuse) else $error("no refusal");
  property p_wake;
    $rose(txd_i) && wake_armed_o && !uart_en_o
      |=> !uart_en_o [*8] ##[1:WK_HI] uart_en_o && module_active_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake timing");
  property p_drop;
    $fell(dtr_on_i) |=> dtr_drop_o ##1 !dtr_drop_o;
  endproperty
  a_drop: assert property (p_drop) else $error("dtr drop pulse");
  property p_usb;
    usb_active_i [*2] |-> module_active_o;
  endproperty
  a_usb: assert property (p_usb) else $error("usb not active");
endmodule
bind upw_ctrl upw_ctrl_properties #(.WAKE_CNT(WAKE_CNT)) u_props (
  .ref_clk_i, .srst_i, .power_save_setting_i, .flow_control_on_setting_i,
  .dtr_on_i, .txd_i, .usb_active_i, .uart_init_done_i, .rx_fifo_ready_o,
  .cts_n_o, .uart_en_o, .module_active_o, .wake_armed_o, .active_setting_o,
  .setting_refused_o, .dtr_drop_o
);

//--- bench/upw_dte_model.sv
`timescale 1ns/1ps
// ****
// Terminal side
// ****
module upw_dte_model #(
  parameter int WAKE_CNT = 10
) (
  input  wire logic ref_clk_i, // Clk
  output logic       rts_o,     // RTS ON
  output logic       dtr_o,     // DTR ON
  output logic       txd_o,     // TXD line
  output logic       vld_o,     // Char strobe
  output logic [7:0] dat_o      // Char
);
  initial
  begin
    {rts_o, dtr_o, txd_o, vld_o} = 4'hE;
    dat_o = 8'h00;
  end
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic lines(input logic r, input logic d);
    rts_o = r;
    dtr_o = d;
  endtask
  task automatic put(input logic [7:0] d);
    vld_o = 1'b1;
    dat_o = d;
    tick();
    vld_o = 1'b0;
    dat_o = ~d;
    tick();
  endtask
  // Dummy char, then hold off
  task automatic wake();
    txd_o = 1'b0;
    tick();
    txd_o = 1'b1;
    put(8'h41);
    repeat (WAKE_CNT + 4) tick();
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int WK = 10;
  logic        clk, srst, flow, init, unsol, usb, work, hrdy;
  logic        rts, dtr, txd, vld, hval, frdy, cts_n, en, act, arm, refd;
  logic        drop;
  logic [15:0] idle;
  logic [7:0]  dat, hdat;
  logic [1:0]  psv, tra, aset, dact;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n;
  upw_ctrl #(.WAKE_CNT(WK), .FRAME_CNT(4)) uut (
    .ref_clk_i(clk), .srst_i(srst), .power_save_setting_i(psv),
    .flow_control_on_setting_i(flow), .idle_frames_i(idle),
    .terminal_ready_action_setting_i(tra), .rts_on_i(rts), .dtr_on_i(dtr),
    .txd_i(txd), .uart_init_done_i(init), .rx_valid_i(vld), .rx_data_i(dat),
    .unsolicited_result_i(unsol), .usb_active_i(usb), .work_pending_i(work),
    .host_rd_ready_i(hrdy), .host_rd_valid_o(hval), .host_rd_data_o(hdat),
    .rx_fifo_ready_o(frdy), .cts_n_o(cts_n), .uart_en_o(en),
    .module_active_o(act), .wake_armed_o(arm), .active_setting_o(aset),
    .setting_refused_o(refd), .dtr_drop_o(drop), .dtr_action_o(dact));
  upw_dte_model #(.WAKE_CNT(WK)) dte (.ref_clk_i(clk), .rts_o(rts),
    .dtr_o(dtr), .txd_o(txd), .vld_o(vld), .dat_o(dat));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wait_en(input logic v);
    n = 0;
    while (en !== v && n < 400)
    begin
      tick();
      n++;
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 17; i++)
      dte.put(8'(i));
    tick();
    chk(16'(frdy), 16'h0);
    chk(16'(cts_n), 16'h1);
    hrdy = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      chk(16'(hdat), 16'(i));
      tick();
    end
    chk(16'(hval), 16'h0);
    hrdy = 1'b0;
  endtask
  task automatic t_refuse();
    flow = 1'b1;
    psv = 2'h2;
    repeat (2) tick();
    chk(16'(refd), 16'h1);
    chk(16'(aset), 16'h0);
    flow = 1'b0;
    repeat (2) tick();
    chk(16'(aset), 16'h2);
  endtask
  task automatic t_rts();
    idle = 16'h0028;
    dte.lines(1'b0, 1'b1);
    wait_en(1'b0);
    chk(16'(n < 8), 16'h1);
    chk(16'(cts_n), 16'h1);
    dte.lines(1'b1, 1'b1);
    wait_en(1'b1);
    chk(16'(n >= WK && n <= WK + 4), 16'h1);
    chk(16'(cts_n), 16'h0);
    dte.lines(1'b0, 1'b1);
    wait_en(1'b0);
    unsol = 1'b1;
    repeat (3) tick();
    chk(16'({en, cts_n}), 16'h3);
    unsol = 1'b0;
    wait_en(1'b0);
    chk(16'(arm), 16'h1);
    dte.wake();
    chk(16'(en), 16'h1);
    wait_en(1'b0);
    chk(16'(n > 120 && n < 400), 16'h1);
  endtask
  task automatic t_dtr();
    flow = 1'b1;
    psv = 2'h3;
    tra = 2'h2;
    dte.lines(1'b0, 1'b0);
    tick();
    chk(16'(drop), 16'h1);
    wait_en(1'b0);
    chk(16'(n < 8), 16'h1);
    chk(16'({aset, dact, arm}), 16'h1C);
    dte.lines(1'b0, 1'b1);
    wait_en(1'b1);
    chk(16'(n >= WK && n <= WK + 4), 16'h1);
    chk(16'(cts_n), 16'h0);
  endtask
  task automatic t_data();
    flow = 1'b0;
    psv = 2'h1;
    idle = 16'h0005;
    wait_en(1'b0);
    chk(16'({en, arm}), 16'h1);
    dte.wake();
    chk(16'({en, act, hval}), 16'h6);
    dte.put(8'hA5);
    tick();
    chk(16'({hval, hdat}), 16'h1A5);
    wait_en(1'b0);
    chk(16'(n >= 150 && n <= 170), 16'h1);
    usb = 1'b1;
    repeat (3) tick();
    chk(16'({act, en}), 16'h2);
    usb = 1'b0;
    work = 1'b1;
    repeat (3) tick();
    chk(16'(act), 16'h1);
    work = 1'b0;
    repeat (4) tick();
    chk(16'(act), 16'h0);
    psv = 2'h0;
    repeat (3) tick();
    chk(16'(cts_n), 16'h0);
  endtask
  initial
  begin
    {srst, flow, unsol, usb, work, hrdy} = 6'h20;
    {psv, tra, init, idle} = {4'h0, 1'b1, 16'h07D0};
    repeat (2) tick();
    srst = 1'b0;
    repeat (2) tick();
    chk(16'({cts_n, aset, act}), 16'h1);
    t_fifo();
    t_refuse();
    t_rts();
    t_dtr();
    t_data();
    summarize();
  end
  initial
  begin
    #40000;
    n_fail++;
    summarize();
  end
endmodule
